// ===== seq_defs.vh
// Constants for the drive run/stop sequencer
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// Sequencer state codes
`define ST_START_DIS 3'h0
`define ST_START_EN 3'h1
`define ST_RUN_ACCEPTED_FLAG 3'h2
`define ST_READY 3'h3
`define ST_ENABLED 3'h4
`define ST_FSTOP 3'h5
`define ST_TRIP_ACT 3'h6
`define ST_TRIP_LATCHED_FLAG 3'h7

// Timing: clock rate and documented times
`define CLK_HZ 200000000
`define FAN_HOLD_S 60
// Sixty seconds of clocks needs 34 bits; a 32-bit product would wrap
`define FAN_HOLD_CYC 34'h2CB417800
`define START_DLY_MAX_MS 30000
`define CYC_PER_MS 18'h30D40

// APB register map (byte addresses)
`define A_CTRL 8'h00
`define A_CFG 8'h04
`define A_STATUS 8'h08
`define A_STATE 8'h0C

// Control register bits
`define C_FWD 0
`define C_REV 1
`define C_JOG 2
`define C_HOLD 3
`define C_PERMIT 4
`define C_FHALT_N 5
`define C_CHALT_N 6
`define C_DIRINV 7
`define C_TRIPCLR 8
`define C_REMOTE 9
`define C_RECONF 10
`define CTRL_RST 32'h00000270

// Config register fields
`define CF_CLR_ON_RUN 16
`define CF_AUTOSTART 17
`define CF_DLY_LSB 0
`define CF_DLY_W 15
`define CFG_RST 32'h00010000

// Status register bits
`define S_TRIP 0
`define S_RUN 1
`define S_JOG 2
`define S_STOP 3
`define S_RDY_SW 4
`define S_ACCEPT 5
`define S_READY 6
`define S_OK 7
`define S_CONT 8
`define S_FAN 9
`define S_DIR 10
`define S_SYSRST 11

`endif

// ===== run_stop_seq.v
// Drive run/stop sequencer with APB register access
`timescale 1ns/1ps
// Operation
// - Run requests need permit, halts and no-fault
// - Run requests only honoured in remote mode
// - Forward plus reverse together means stop
// - Programmable start delay before ramping, 0-32767 ms
// - Hold flag latches forward/reverse run requests
// - Jog runs at jog speed, release ramps down
// - Run_accepted_flag to ready needs contactor closed
// - Permit loss while running coasts the motor
// - Fast halt ramps down, latched until done
// - Freewheel halt coasts, latched until done
// - Direction invert flips demanded rotation
// - Trip-clear rising edge clears latched trips
// - Optionally run rising edge clears trips
// - Autostart bit has no effect; run must rise in start enabled
// - Flags: trip, enabled, jog, stopping
// - Output contactor closed except trip/reconfig
// - Run_accepted_flag flag while awaiting contactor, deflux
// - System reset pulse one cycle on run/jog
// - State codes 0..7, reset value 0
// - No-fault flag cleared on trip, set when run removed
// - Fan on while running, off 60s after stop
`include "seq_defs.vh"

module run_stop_seq #(
    parameter [33:0] FAN_CYC = `FAN_HOLD_CYC,
    parameter [17:0] MS_CYC = `CYC_PER_MS
) (
    input wire sys_clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire contactor_closed,
    input wire trip_in,
    input wire stop_done,
    input wire deflux_done,
    output reg trip_latched_flag,
    output reg running_flag,
    output reg jogging_flag,
    output reg stopping_flag,
    output reg ready_sw_on_flag,
    output reg run_accepted_flag,
    output reg ready_flag,
    output reg no_fault_ok,
    output reg out_contactor,
    output reg fan_ctrl_out,
    output reg demanded_dir_out,
    output reg sys_reset_out,
    output reg ramp_go,
    output reg fast_ramp,
    output reg coast_out,
    output reg jog_sel,
    output reg [2:0] seq_state
);

// ----------------------------------------
// Register bus
// ----------------------------------------
reg [31:0] ctrl_q;
reg [31:0] cfg_q;
wire wr_en = psel && penable && pwrite;
wire hit = (paddr == `A_CTRL) || (paddr == `A_CFG) ||
    (paddr == `A_STATUS) || (paddr == `A_STATE);

// Zero wait states; unmapped addresses answer with an error
assign pready = 1'b1;
assign pslverr = psel && penable && !hit;

always @(posedge sys_clk) begin
    if (!nrst) begin
        ctrl_q <= `CTRL_RST;
        cfg_q <= `CFG_RST;
    end else if (wr_en) begin
        if (paddr == `A_CTRL)
            ctrl_q <= pwdata;
        if (paddr == `A_CFG)
            cfg_q <= pwdata;
    end
end

wire [31:0] status_w = {20'h00000, sys_reset_out, demanded_dir_out,
    fan_ctrl_out, out_contactor, no_fault_ok, ready_flag,
    run_accepted_flag, ready_sw_on_flag, stopping_flag,
    jogging_flag, running_flag, trip_latched_flag};

always @* begin
    case (paddr)
        `A_CTRL: prdata = ctrl_q;
        `A_CFG: prdata = cfg_q;
        `A_STATUS: prdata = status_w;
        `A_STATE: prdata = {29'h00000000, seq_state};
        default: prdata = 32'h00000000;
    endcase
end

// ----------------------------------------
// Command qualification
// ----------------------------------------
wire fwd = ctrl_q[`C_FWD];
wire rev = ctrl_q[`C_REV];
wire jog = ctrl_q[`C_JOG];
wire hold = ctrl_q[`C_HOLD];
wire permit = ctrl_q[`C_PERMIT];
wire fhalt_n = ctrl_q[`C_FHALT_N];
wire chalt_n = ctrl_q[`C_CHALT_N];
wire remote = ctrl_q[`C_REMOTE];
wire reconf = ctrl_q[`C_RECONF];

reg fwd_lat_q;
reg rev_lat_q;
reg run_prev_q;
reg clr_prev_q;
reg first_q;
reg fstop_lat_q;
reg coast_lat_q;

// Both directions at once cancel each other
wire fwd_eff = (fwd || fwd_lat_q) && !(fwd && rev);
wire rev_eff = (rev || rev_lat_q) && !(fwd && rev);
wire run_cmd = remote && (fwd_eff || rev_eff);
wire jog_cmd = remote && jog && !run_cmd;
wire perm_ok = permit && fhalt_n && chalt_n && no_fault_ok &&
    !fstop_lat_q && !coast_lat_q;
wire run_rise = run_cmd && !run_prev_q;
// After power-up a present run counts as an edge only if autostart set
wire run_start = run_rise && (!first_q || cfg_q[`CF_AUTOSTART]);
wire clr_rise = ctrl_q[`C_TRIPCLR] && !clr_prev_q;
wire trip_clear = clr_rise ||
    (cfg_q[`CF_CLR_ON_RUN] && run_rise);

always @(posedge sys_clk) begin
    if (!nrst) begin
        fwd_lat_q <= 1'b0;
        rev_lat_q <= 1'b0;
        run_prev_q <= 1'b0;
        clr_prev_q <= 1'b0;
        first_q <= 1'b1;
    end else begin
        fwd_lat_q <= hold && (fwd_lat_q || fwd) && !rev;
        rev_lat_q <= hold && (rev_lat_q || rev) && !fwd;
        // Without autostart, a run held since power-up is seen as old
        run_prev_q <= run_cmd;
        clr_prev_q <= ctrl_q[`C_TRIPCLR];
        first_q <= 1'b0;
    end
end

// ----------------------------------------
// Sequencer
// ----------------------------------------
reg [2:0] st_q;
reg [2:0] st_d;
reg [31:0] dly_q;
reg [17:0] ms_q;
reg [33:0] fan_q;
reg jog_mode_q;
wire [14:0] dly_ms = cfg_q[`CF_DLY_LSB +: `CF_DLY_W];
wire want = run_cmd || jog_cmd;
wire active = (st_q == `ST_ENABLED);

always @* begin
    st_d = st_q;
    case (st_q)
        `ST_START_DIS: begin
            if (perm_ok && !want)
                st_d = `ST_START_EN;
        end
        `ST_START_EN: begin
            if (!perm_ok)
                st_d = `ST_START_DIS;
            else if (run_start || jog_cmd)
                st_d = `ST_RUN_ACCEPTED_FLAG;
        end
        `ST_RUN_ACCEPTED_FLAG: begin
            if (!want || !permit || !chalt_n)
                st_d = `ST_START_DIS;
            else if (contactor_closed && deflux_done)
                st_d = `ST_READY;
        end
        `ST_READY: begin
            if (!want || !permit || !chalt_n)
                st_d = `ST_START_DIS;
            else
                st_d = `ST_ENABLED;
        end
        `ST_ENABLED: begin
            if (!permit || !chalt_n)
                st_d = `ST_START_DIS;
            else if (!fhalt_n)
                st_d = `ST_FSTOP;
            else if (!want && stop_done)
                st_d = `ST_START_DIS;
        end
        `ST_FSTOP: begin
            if (!chalt_n || !permit)
                st_d = `ST_START_DIS;
            else if (stop_done)
                st_d = `ST_START_DIS;
        end
        `ST_TRIP_ACT: begin
            if (stop_done || !permit)
                st_d = `ST_TRIP_LATCHED_FLAG;
        end
        `ST_TRIP_LATCHED_FLAG: begin
            if (trip_clear)
                st_d = `ST_START_DIS;
        end
        default: st_d = `ST_START_DIS;
    endcase
    if (trip_in && st_q != `ST_TRIP_LATCHED_FLAG)
        st_d = `ST_TRIP_ACT;
end

always @(posedge sys_clk) begin
    if (!nrst) begin
        st_q <= `ST_START_DIS;
        jog_mode_q <= 1'b0;
        fstop_lat_q <= 1'b0;
        coast_lat_q <= 1'b0;
        no_fault_ok <= 1'b1;
        dly_q <= 32'h00000000;
        ms_q <= 18'h00000;
        fan_q <= 34'h000000000;
    end else begin
        st_q <= st_d;
        if (st_q == `ST_START_EN && st_d == `ST_RUN_ACCEPTED_FLAG)
            jog_mode_q <= !run_start;
        // Halts stay latched until the stop sequence finishes
        if (!fhalt_n && active)
            fstop_lat_q <= 1'b1;
        else if (!active && st_q != `ST_FSTOP)
            fstop_lat_q <= 1'b0;
        if (!chalt_n && st_q != `ST_START_DIS)
            coast_lat_q <= 1'b1;
        else if (st_q == `ST_START_DIS)
            coast_lat_q <= 1'b0;
        // Trip wins over recovery in the same cycle
        if (trip_in)
            no_fault_ok <= 1'b0;
        else if (!run_cmd)
            no_fault_ok <= 1'b1;
        // Start delay counted in milliseconds
        if (!active) begin
            dly_q <= 32'h00000000;
            ms_q <= 18'h00000;
        end else if (dly_q < {17'h00000, dly_ms}) begin
            if (ms_q == MS_CYC - 18'h00001) begin
                ms_q <= 18'h00000;
                dly_q <= dly_q + 32'h00000001;
            end else begin
                ms_q <= ms_q + 18'h00001;
            end
        end
        if (active)
            fan_q <= FAN_CYC;
        else if (fan_q != 34'h000000000)
            fan_q <= fan_q - 34'h000000001;
    end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
wire dly_done = dly_q >= {17'h00000, dly_ms};

always @(posedge sys_clk) begin
    if (!nrst) begin
        trip_latched_flag <= 1'b0;
        running_flag <= 1'b0;
        jogging_flag <= 1'b0;
        stopping_flag <= 1'b0;
        ready_sw_on_flag <= 1'b0;
        run_accepted_flag <= 1'b0;
        ready_flag <= 1'b0;
        out_contactor <= 1'b0;
        fan_ctrl_out <= 1'b0;
        demanded_dir_out <= 1'b0;
        sys_reset_out <= 1'b0;
        ramp_go <= 1'b0;
        fast_ramp <= 1'b0;
        coast_out <= 1'b0;
        jog_sel <= 1'b0;
        seq_state <= `ST_START_DIS;
    end else begin
        seq_state <= st_q;
        trip_latched_flag <= (st_q == `ST_TRIP_ACT) ||
            (st_q == `ST_TRIP_LATCHED_FLAG);
        running_flag <= active;
        jogging_flag <= active && jog_mode_q;
        stopping_flag <= (active && !want) ||
            (st_q == `ST_FSTOP);
        ready_sw_on_flag <= (st_q == `ST_START_EN);
        run_accepted_flag <= (st_q == `ST_RUN_ACCEPTED_FLAG);
        ready_flag <= (st_q == `ST_READY);
        out_contactor <= !(trip_in || st_q == `ST_TRIP_ACT ||
            st_q == `ST_TRIP_LATCHED_FLAG || reconf);
        fan_ctrl_out <= active || (fan_q != 34'h000000000);
        demanded_dir_out <= rev_eff ^ ctrl_q[`C_DIRINV];
        sys_reset_out <= (st_q == `ST_READY) &&
            (st_d == `ST_ENABLED);
        ramp_go <= active && want && fhalt_n && dly_done;
        fast_ramp <= (st_q == `ST_FSTOP);
        coast_out <= !(active || st_q == `ST_FSTOP);
        jog_sel <= active && jog_mode_q;
    end
end

endmodule

// ===== run_stop_seq_props.sv
// Port assertions for the run/stop sequencer
`timescale 1ns/1ps
`include "seq_defs.vh"
module run_stop_seq_props (
    input wire sys_clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire contactor_closed,
    input wire running_flag,
    input wire no_fault_ok,
    input wire fan_ctrl_out,
    input wire sys_reset_out,
    input wire [2:0] seq_state
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_rst_one_cyc: assert property (sys_reset_out |=> !sys_reset_out)
        else $error("system reset pulse too long");
    a_rst_in_run: assert property ($rose(sys_reset_out) |->
        seq_state == `ST_READY ##1 seq_state == `ST_ENABLED)
        else $error("system reset pulse outside run entry");
    a_ready_contact: assert property (seq_state == `ST_READY |->
        $past(contactor_closed) || $past(contactor_closed, 2))
        else $error("ready without contactor feedback");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h0C
        |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && penable && paddr <= 8'h0C
        && paddr[1:0] == 2'h0 |-> !pslverr && pready)
        else $error("mapped access refused");
    a_run_healthy: assert property ($rose(running_flag) |-> no_fault_ok)
        else $error("run entered while unhealthy");
    a_fault_trip: assert property ($fell(no_fault_ok) |-> ##[0:2]
        seq_state == `ST_TRIP_ACT || seq_state == `ST_TRIP_LATCHED_FLAG)
        else $error("healthy flag cleared without trip");
    a_fan_on_run: assert property (running_flag |-> ##[0:2] fan_ctrl_out)
        else $error("fan off while running");
    a_reset_idle: assert property (disable iff (1'b0)
        !nrst ##1 !nrst |-> seq_state == `ST_START_DIS && !running_flag)
        else $error("reset state not start disabled");
endmodule

bind run_stop_seq run_stop_seq_props props (.sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .contactor_closed(contactor_closed),
    .running_flag(running_flag), .no_fault_ok(no_fault_ok),
    .fan_ctrl_out(fan_ctrl_out), .sys_reset_out(sys_reset_out),
    .seq_state(seq_state));

// ===== seq_partner.sv
// Contactor feedback and motor standstill model
`timescale 1ns/1ps
module seq_partner (
    input wire sys_clk,
    input wire [3:0] dly,
    input wire out_contactor,
    input wire moving,
    output reg contactor_closed = 1'b0,
    output reg stop_done = 1'b1,
    output wire deflux_done
);
    reg [3:0] c_cnt_q = 4'h0;
    reg [3:0] s_cnt_q = 4'h0;
    assign deflux_done = 1'b1;
    // ----
    // Mechanics
    // ----
    // Feedback lags the coil so the sequencer really has to wait
    always @(posedge sys_clk) begin
        if (out_contactor == contactor_closed)
            c_cnt_q <= 4'h0;
        else
            c_cnt_q <= c_cnt_q + 4'h1;
        if (c_cnt_q >= dly)
            contactor_closed <= out_contactor;
        if (moving)
            s_cnt_q <= 4'h0;
        else if (!stop_done)
            s_cnt_q <= s_cnt_q + 4'h1;
        stop_done <= !moving && s_cnt_q >= dly;
    end
endmodule

// ===== test_drive_run_stop_sequencer.sv
// Self-checking bench for the run/stop sequencer
`timescale 1ns/1ps
`include "seq_defs.vh"
module test_drive_run_stop_sequencer;
    localparam FAN = 200;
    localparam [31:0] B = `CTRL_RST;
    localparam [31:0] FWD = 32'h1 << `C_FWD;
    localparam [31:0] REV = 32'h1 << `C_REV;
    localparam [31:0] INV = 32'h1 << `C_DIRINV;
    localparam [31:0] CLR = 32'h1 << `C_TRIPCLR;
    localparam [31:0] RCF = 32'h1 << `C_RECONF;
    localparam [31:0] JOG = 32'h1 << `C_JOG;
    localparam [31:0] FH = 32'h1 << `C_FHALT_N;
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg trip_in = 1'b0;
    reg [3:0] dly = 4'h2;
    reg [31:0] rd;
    reg er;
    integer err_total = 0;
    integer checks = 0;
    integer n;
    wire [31:0] prdata;
    wire [2:0] seq_state;
    wire pready, pslverr, cc, sd, dd, trp, run, jog, stp, rsw, acc, rdy;
    wire ok, oc, fan, dir, srst, rgo, frmp, cst, jsel;
    run_stop_seq #(.FAN_CYC(FAN), .MS_CYC(4)) dut (.sys_clk(sys_clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .contactor_closed(cc), .trip_in(trip_in),
        .stop_done(sd), .deflux_done(dd), .trip_latched_flag(trp),
        .running_flag(run), .jogging_flag(jog), .stopping_flag(stp),
        .ready_sw_on_flag(rsw), .run_accepted_flag(acc), .ready_flag(rdy),
        .no_fault_ok(ok), .out_contactor(oc), .fan_ctrl_out(fan),
        .demanded_dir_out(dir), .sys_reset_out(srst), .ramp_go(rgo),
        .fast_ramp(frmp), .coast_out(cst), .jog_sel(jsel),
        .seq_state(seq_state));
    seq_partner far (.sys_clk(sys_clk), .dly(dly), .out_contactor(oc),
        .moving(rgo), .contactor_closed(cc), .stop_done(sd),
        .deflux_done(dd));
    // ----
    // Helpers
    // ----
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1)
                @(posedge sys_clk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task wait_st(input [2:0] s);
        begin
            n = 0;
            while (seq_state !== s && n < 100) begin
                n = n + 1;
                @(posedge sys_clk);
            end
            @(posedge sys_clk);
            chk(seq_state, s);
        end
    endtask
    task test_done;
        begin
            $display("err_total=%0d checks=%0d", err_total, checks);
            if (err_total == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // ----
    // Scenarios
    // ----
    task t_regs;
        begin
            apb(0, `A_CTRL, 0);
            chk(rd, `CTRL_RST);
            apb(0, `A_CFG, 0);
            chk(rd, `CFG_RST);
            apb(0, 8'h10, 0);
            chk(rd, 32'h0);
            chk(er, 1'b1);
            wait_st(`ST_START_EN);
            chk(rsw, 1'b1);
        end
    endtask
    task t_gate;
        begin
            apb(1, `A_CTRL, B & ~(32'h1 << `C_REMOTE) | FWD);
            repeat (8) @(posedge sys_clk);
            chk(acc, 1'b0);
            chk(seq_state, `ST_START_EN);
            apb(1, `A_CTRL, B);
            apb(1, `A_CTRL, B & ~(32'h1 << `C_PERMIT) | FWD);
            repeat (8) @(posedge sys_clk);
            chk(acc, 1'b0);
            chk(seq_state, `ST_START_DIS);
            apb(1, `A_CTRL, B);
        end
    endtask
    task t_run;
        begin
            dly = 4'h8;
            apb(1, `A_CFG, `CFG_RST | 32'hA);
            apb(1, `A_CTRL, B | RCF);
            @(posedge sys_clk);
            chk(oc, 1'b0);
            repeat (12) @(posedge sys_clk);
            apb(1, `A_CTRL, B | FWD);
            wait_st(`ST_RUN_ACCEPTED_FLAG);
            chk({acc, rdy}, 2'h2);
            wait_st(`ST_ENABLED);
            chk({run, fan, rgo}, 3'h6);
            repeat (44) @(posedge sys_clk);
            chk(rgo, 1'b1);
            apb(1, `A_CTRL, B | FWD | INV);
            @(posedge sys_clk);
            chk(dir, 1'b1);
        end
    endtask
    task t_stop;
        begin
            apb(1, `A_CTRL, B | FWD | REV);
            @(posedge sys_clk);
            chk(rgo, 1'b0);
            n = 0;
            while (fan === 1'b1 && n < 2 * FAN) begin
                n = n + 1;
                @(posedge sys_clk);
            end
            chk(n > FAN - 8 && n < FAN + 24, 1'b1);
            apb(1, `A_CTRL, B);
        end
    endtask
    task t_trip;
        begin
            apb(1, `A_CTRL, B | FWD);
            wait_st(`ST_ENABLED);
            trip_in <= 1'b1;
            wait_st(`ST_TRIP_ACT);
            trip_in <= 1'b0;
            wait_st(`ST_TRIP_LATCHED_FLAG);
            chk({trp, ok, oc}, 3'h4);
            apb(1, `A_CTRL, B);
            @(posedge sys_clk);
            chk({ok, seq_state}, 4'hF);
            apb(1, `A_CTRL, B | CLR);
            wait_st(`ST_START_EN);
            chk(trp, 1'b0);
            trip_in <= 1'b1;
            wait_st(`ST_TRIP_ACT);
            trip_in <= 1'b0;
            wait_st(`ST_TRIP_LATCHED_FLAG);
            apb(1, `A_CTRL, B | FWD);
            wait_st(`ST_START_DIS);
            chk(trp, 1'b0);
            apb(1, `A_CTRL, B);
            wait_st(`ST_START_EN);
        end
    endtask
    task t_jog;
        begin
            apb(1, `A_CTRL, B | JOG);
            wait_st(`ST_ENABLED);
            chk({jog, jsel}, 2'h3);
            repeat (44) @(posedge sys_clk);
            apb(1, `A_CTRL, B);
            @(posedge sys_clk);
            chk({stp, rgo}, 2'h2);
            wait_st(`ST_START_EN);
        end
    endtask
    task t_halt;
        begin
            apb(1, `A_CTRL, B | FWD);
            wait_st(`ST_ENABLED);
            repeat (44) @(posedge sys_clk);
            apb(1, `A_CTRL, (B & ~FH) | FWD);
            wait_st(`ST_FSTOP);
            chk({frmp, stp, cst}, 3'h6);
            wait_st(`ST_START_DIS);
            apb(1, `A_CTRL, B);
            wait_st(`ST_START_EN);
        end
    endtask
    initial begin
        #100000;
        err_total = err_total + 1;
        test_done;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        chk(seq_state, `ST_START_DIS);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_regs;
        t_gate;
        t_run;
        t_stop;
        t_jog;
        t_halt;
        t_trip;
        test_done;
    end
endmodule
